/* File: src/sct_decode.sv */
// Opcode decoder: bytes, clock counts and class of every opcode.
// Assumes: a full opcode byte; used combinationally by the sequencer.
module sct_decode (
  // Opcode from fetch
  input wire logic [7:0] opcode,
  // Size and timing
  output logic [sct_pkg::SCT_LEN_W-1:0] len,
  output logic [sct_pkg::SCT_CYC_W-1:0] cyc,
  output logic [sct_pkg::SCT_CYC_W-1:0] cyc_taken,
  // Class
  output logic cond_branch,
  output logic bank_reg_op,
  output logic ptr_indirect_op,
  output logic [2:0] reg_index,
  output logic ext_move,
  output logic ext_write,
  output logic ext_by_sixteen_bit_data_pointer,
  output logic code_load,
  output logic code_by_pc
);
  import sct_pkg::*;

  logic [7:0] op;
  logic [2:0] col;
  logic [SCT_ENT_W-1:0] ent;

  always_comb begin
    op = (opcode == SCT_OP_SPARE) ? SCT_OP_NOP : opcode;
    if (op[3])
      col = SCT_COL_BANK;
    else if (op[2:1] == 2'h3)
      col = SCT_COL_IND;
    else
      col = op[2:0];
    ent = SCT_TIMING[col][op[7:4] * SCT_ENT_W +: SCT_ENT_W];
    len = ent[SCT_LEN_POS +: SCT_LEN_W];
    cyc = ent[SCT_CYC_POS +: SCT_CYC_W];
    cyc_taken = ent[SCT_TKN_POS +: SCT_CYC_W];
    cond_branch = (cyc_taken != SCT_REMAIN_ZERO);
    bank_reg_op = op[3];
    // Pointer moves to flash are register indirect too
    ptr_indirect_op = (col == SCT_COL_IND) ||
                      ((op[7:5] == 3'h7) && (op[3:1] == 3'h1));
    reg_index = op[3] ? op[2:0] : {2'h0, op[0]};
    ext_move = (op[7:5] == 3'h7) && (op[3:0] inside {4'h0, 4'h2, 4'h3});
    ext_write = op[4];
    ext_by_sixteen_bit_data_pointer = (op[3:0] == 4'h0);
    code_load = (op == SCT_OP_CODE_DP) || (op == SCT_OP_CODE_PC);
    code_by_pc = (op == SCT_OP_CODE_PC);
  end

endmodule // sct_decode

/* File: src/sct_flash_route.sv */
// Flash request routing for code loads and external-space moves.
// Assumes: operand values are valid in the issue cycle.
module sct_flash_route (
  // Access class
  input wire logic ext_move,
  input wire logic ext_write,
  input wire logic ext_by_sixteen_bit_data_pointer,
  input wire logic code_load,
  input wire logic code_by_pc,
  // Operand values
  input wire logic [7:0] acc_value,
  input wire logic [15:0] data_ptr_value,
  input wire logic [15:0] pc_next,
  input wire logic [7:0] ptr_reg_value,
  // Flash request
  output logic rd,
  output logic wr,
  output logic [15:0] addr
);
  import sct_pkg::*;

  always_comb begin
    rd = code_load || (ext_move && !ext_write);
    // No external bus: writes land in flash, gated there by its own enable
    wr = ext_move && ext_write;
    if (code_load)
      addr = (code_by_pc ? pc_next : data_ptr_value) + {8'h00, acc_value};
    else if (ext_by_sixteen_bit_data_pointer)
      addr = data_ptr_value;
    else
      addr = {SCT_XADDR_HI, ptr_reg_value};
  end

endmodule // sct_flash_route

/* File: src/sct_pkg.sv */
// Package: opcode timing tables, states and constants of the timing unit.
// Assumes: one system clock; opcodes come from fetch logic on that clock.
package sct_pkg;

  typedef enum logic [2:0] {
    SCT_IDLE = 3'b001,
    SCT_EXEC = 3'b010,
    SCT_TAKEN = 3'b100
  } sct_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Widths and field positions of one table entry {len, cycles, taken}
  localparam int SCT_LEN_W = 2;
  localparam int SCT_CYC_W = 4;
  localparam int SCT_ENT_W = 12;
  localparam int SCT_LEN_POS = 8;
  localparam int SCT_CYC_POS = 4;
  localparam int SCT_TKN_POS = 0;
  localparam logic [2:0] SCT_COL_IND = 3'h6;
  localparam logic [2:0] SCT_COL_BANK = 3'h7;

  ////////////////////////////////////////////////////////////////////////////
  // Cycle counts
  localparam logic [SCT_CYC_W-1:0] SCT_REMAIN_ZERO = 4'h0;
  localparam logic [SCT_CYC_W-1:0] SCT_REMAIN_LAST = 4'h1;
  // Branch outcome is taken in the next to last not-taken cycle
  localparam logic [SCT_CYC_W-1:0] SCT_REMAIN_RESOLVE = 4'h2;
  localparam logic [SCT_CYC_W-1:0] SCT_TAKEN_EXTRA = 4'h1;

  ////////////////////////////////////////////////////////////////////////////
  // Opcodes with special handling
  localparam logic [7:0] SCT_OP_NOP = 8'h00;
  localparam logic [7:0] SCT_OP_SPARE = 8'ha5;
  localparam logic [7:0] SCT_OP_CODE_DP = 8'h93;
  localparam logic [7:0] SCT_OP_CODE_PC = 8'h83;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [15:0] SCT_RST_ADDR = 16'h0000;
  localparam logic [SCT_LEN_W-1:0] SCT_RST_LEN = 2'h0;
  localparam logic [SCT_CYC_W-1:0] SCT_RST_CYC = 4'h0;
  localparam logic [2:0] SCT_RST_REG = 3'h0;
  // Upper flash address byte for 8-bit pointer external moves
  localparam logic [7:0] SCT_XADDR_HI = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // class clocks
  // class clocks
  // Timing per low-nibble column; 3 hex digits per row, row f leftmost.
  // Columns 0..5 by low nibble, 6 = indirect pointer, 7 = bank register.
  localparam logic [191:0] SCT_TIMING [0:7] = '{
    {96'h130130220220220220330230, 96'h223223223223334334334110},
    {96'h230230230230230230230230, 96'h230230230230230230230230},
    {96'h130130220220220220220220, 96'h220220220220150150340340},
    {96'h130130110110110110130130, 96'h130330330330110110110110},
    {96'h110110110110334140220180, 96'h220220220220220220110110},
    {96'h220220334220334110220330, 96'h330220220220220220220220},
    {96'h120120120120345220120220, 96'h220120120120120120120120},
    {96'h110110223110334220110220, 96'h220110110110110110110110}
  };

endpackage

/* File: src/sct_timing.sv */
// Instruction timing unit of the pipelined 8-bit core: decodes each
// issued opcode, counts its execution in system clocks and routes
// code loads and external-space moves to program flash.
// Assumes: fetch, execute and register file run on sys_clk; the branch
// outcome is valid in the next to last cycle of a not-taken branch.
//
// Overview of operation
// - Opcodes, addressing modes and flag effects follow the classic set.
// - Execution is counted in plain system clocks, no machine cycles.
// - Most instructions take as many clocks as they have bytes.
// - A taken conditional branch takes one clock more than not taken.
// - The external-space move reaches on-chip program flash.
// - Accumulator with bank register ops are one byte and one clock.
// - Accumulator ops through a pointer register take two clocks.
// - Accumulator ops on a direct byte are two bytes and two clocks.
// - Logic immediate into a direct byte is three bytes, three clocks.
// - Direct to direct move is three bytes and three clocks.
// - Loading the data pointer immediate is three bytes, three clocks.
// - Code load at pointer plus accumulator is one byte, three clocks.
// - Storing the accumulator through a pointer takes two clocks.
// - Clear, complement, rotates and swap of A take one clock.
// - The spare opcode acts exactly as no-op.
// - Indirect compare and branch takes four or five clocks.
module sct_timing (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Issue from fetch
  input wire logic opcode_valid,
  input wire logic [7:0] opcode,
  // Operand values for flash access
  input wire logic [7:0] acc_value,
  input wire logic [15:0] data_ptr_value,
  input wire logic [15:0] pc_next,
  input wire logic [7:0] ptr_reg_value,
  // Branch outcome from execute
  input wire logic branch_taken,
  // Sequencing
  output logic issue_ready_ff,
  output logic instr_done_ff,
  output logic [sct_pkg::SCT_LEN_W-1:0] instr_len_ff,
  output logic [sct_pkg::SCT_CYC_W-1:0] instr_cycles_ff,
  output logic cond_branch_ff,
  output logic branch_taken_ff,
  // Operand routing
  output logic bank_reg_op_ff,
  output logic ptr_indirect_op_ff,
  output logic [2:0] reg_index_ff,
  // Program flash access
  output logic flash_rd_ff,
  output logic flash_wr_ff,
  output logic [15:0] flash_addr_ff
);
  import sct_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Decode and flash routing
  logic [SCT_LEN_W-1:0] dec_len;
  logic [SCT_CYC_W-1:0] dec_cyc;
  logic [SCT_CYC_W-1:0] dec_cyc_taken;
  logic dec_branch;
  logic dec_bank;
  logic dec_ind;
  logic [2:0] dec_reg;
  logic dec_ext;
  logic dec_ext_wr;
  logic dec_ext_dp;
  logic dec_code;
  logic dec_code_pc;
  logic route_rd;
  logic route_wr;
  logic [15:0] route_addr;

  sct_decode u_decode (
    .opcode(opcode),
    .len(dec_len),
    .cyc(dec_cyc),
    .cyc_taken(dec_cyc_taken),
    .cond_branch(dec_branch),
    .bank_reg_op(dec_bank),
    .ptr_indirect_op(dec_ind),
    .reg_index(dec_reg),
    .ext_move(dec_ext),
    .ext_write(dec_ext_wr),
    .ext_by_sixteen_bit_data_pointer(dec_ext_dp),
    .code_load(dec_code),
    .code_by_pc(dec_code_pc)
  );

  sct_flash_route u_route (
    .ext_move(dec_ext),
    .ext_write(dec_ext_wr),
    .ext_by_sixteen_bit_data_pointer(dec_ext_dp),
    .code_load(dec_code),
    .code_by_pc(dec_code_pc),
    .acc_value(acc_value),
    .data_ptr_value(data_ptr_value),
    .pc_next(pc_next),
    .ptr_reg_value(ptr_reg_value),
    .rd(route_rd),
    .wr(route_wr),
    .addr(route_addr)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  sct_state_t state_ff;
  sct_state_t nxt_state;
  logic [SCT_CYC_W-1:0] remain_ff;
  logic [SCT_CYC_W-1:0] nxt_remain;
  logic nxt_ready;
  logic nxt_done;
  logic [SCT_LEN_W-1:0] nxt_len;
  logic [SCT_CYC_W-1:0] nxt_cycles;
  logic nxt_branch;
  logic nxt_taken;
  logic nxt_bank;
  logic nxt_ind;
  logic [2:0] nxt_reg;
  logic nxt_rd;
  logic nxt_wr;
  logic [15:0] nxt_addr;
  logic issue;
  logic resolve;

  // Ready in the last cycle so one-clock instructions issue back to back
  assign issue = opcode_valid && issue_ready_ff;
  assign resolve = (state_ff == SCT_EXEC) && cond_branch_ff &&
                   (remain_ff == SCT_REMAIN_RESOLVE);

  always_comb begin
    nxt_state = state_ff;
    nxt_remain = remain_ff;
    nxt_len = instr_len_ff;
    nxt_cycles = instr_cycles_ff;
    nxt_branch = cond_branch_ff;
    nxt_taken = branch_taken_ff;
    nxt_bank = bank_reg_op_ff;
    nxt_ind = ptr_indirect_op_ff;
    nxt_reg = reg_index_ff;
    nxt_addr = flash_addr_ff;
    nxt_rd = 1'b0;
    nxt_wr = 1'b0;
    case (state_ff)
      SCT_IDLE: begin
        nxt_remain = SCT_REMAIN_ZERO;
      end
      SCT_EXEC, SCT_TAKEN: begin
        // Taken branch holds one more clock
        if (resolve && branch_taken) begin
          nxt_state = SCT_TAKEN;
          nxt_taken = 1'b1;
          nxt_cycles = instr_cycles_ff + SCT_TAKEN_EXTRA;
        end else if (remain_ff == SCT_REMAIN_LAST) begin
          nxt_state = SCT_IDLE;
          nxt_remain = SCT_REMAIN_ZERO;
        end else begin
          nxt_remain = remain_ff - SCT_REMAIN_LAST;
        end
      end
      default: begin
        nxt_state = SCT_IDLE;
        nxt_remain = SCT_REMAIN_ZERO;
      end
    endcase
    if (issue) begin
      nxt_state = SCT_EXEC;
      nxt_remain = dec_cyc;
      nxt_len = dec_len;
      nxt_cycles = dec_cyc;
      nxt_branch = dec_branch;
      nxt_taken = 1'b0;
      nxt_bank = dec_bank;
      nxt_ind = dec_ind;
      nxt_reg = dec_reg;
      // Flash request in the first clock
      nxt_rd = route_rd;
      nxt_wr = route_wr;
      nxt_addr = route_addr;
    end
    nxt_done = (nxt_state != SCT_IDLE) && (nxt_remain == SCT_REMAIN_LAST);
    nxt_ready = (nxt_state == SCT_IDLE) || nxt_done;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_ff <= SCT_IDLE;
      remain_ff <= SCT_REMAIN_ZERO;
      issue_ready_ff <= 1'b1;
      instr_done_ff <= 1'b0;
      instr_len_ff <= SCT_RST_LEN;
      instr_cycles_ff <= SCT_RST_CYC;
      cond_branch_ff <= 1'b0;
      branch_taken_ff <= 1'b0;
      bank_reg_op_ff <= 1'b0;
      ptr_indirect_op_ff <= 1'b0;
      reg_index_ff <= SCT_RST_REG;
      flash_rd_ff <= 1'b0;
      flash_wr_ff <= 1'b0;
      flash_addr_ff <= SCT_RST_ADDR;
    end else begin
      state_ff <= nxt_state;
      remain_ff <= nxt_remain;
      issue_ready_ff <= nxt_ready;
      instr_done_ff <= nxt_done;
      instr_len_ff <= nxt_len;
      instr_cycles_ff <= nxt_cycles;
      cond_branch_ff <= nxt_branch;
      branch_taken_ff <= nxt_taken;
      bank_reg_op_ff <= nxt_bank;
      ptr_indirect_op_ff <= nxt_ind;
      reg_index_ff <= nxt_reg;
      flash_rd_ff <= nxt_rd;
      flash_wr_ff <= nxt_wr;
      flash_addr_ff <= nxt_addr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  logic acc_src_row;
  assign acc_src_row = opcode[7:4] inside
    {4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9, 4'he};

  sequence s_done_in_1;
    instr_done_ff;
  endsequence

  sequence s_done_in_2;
    !instr_done_ff ##1 instr_done_ff;
  endsequence

  sequence s_done_in_3;
    !instr_done_ff [*2] ##1 instr_done_ff;
  endsequence

  a_bank_reg_ops: assert property (
    issue && opcode[3] && acc_src_row |=>
      (instr_len_ff == 2'h1) ##0 s_done_in_1)
    else $error("bank register op not one byte one clock");

  a_ptr_ind_ops: assert property (
    issue && (opcode[3:1] == 3'h3) && acc_src_row |=>
      (instr_len_ff == 2'h1) ##0 s_done_in_2)
    else $error("indirect accumulator op not two clocks");

  a_direct_ops: assert property (
    issue && (opcode[3:0] == 4'h5) && acc_src_row |=>
      (instr_len_ff == 2'h2) ##0 s_done_in_2)
    else $error("direct accumulator op not two bytes two clocks");

  a_logic_imm_dir: assert property (
    issue && (opcode inside {8'h43, 8'h53, 8'h63}) |=>
      (instr_len_ff == 2'h3) ##0 s_done_in_3)
    else $error("logic immediate to direct not three clocks");

  a_move_dir_dir: assert property (
    issue && (opcode == 8'h85) |=>
      (instr_len_ff == 2'h3) ##0 s_done_in_3)
    else $error("direct to direct move not three clocks");

  a_sixteen_bit_data_pointer_load: assert property (
    issue && (opcode == 8'h90) |=>
      (instr_len_ff == 2'h3) ##0 s_done_in_3)
    else $error("data pointer load not three clocks");

  a_code_byte_load: assert property (
    issue && (opcode == 8'h93) |=>
      flash_rd_ff && (instr_len_ff == 2'h1) &&
      (flash_addr_ff == $past(data_ptr_value) + {8'h00, $past(acc_value)})
      ##0 s_done_in_3)
    else $error("code byte load wrong address or timing");

  a_store_ind: assert property (
    issue && (opcode inside {8'hf6, 8'hf7}) |=>
      (instr_len_ff == 2'h1) ##0 s_done_in_2)
    else $error("indirect store not two clocks");

  a_acc_manip: assert property (
    issue && (opcode inside
      {8'he4, 8'hf4, 8'h03, 8'h13, 8'h23, 8'h33, 8'hc4}) |=> s_done_in_1)
    else $error("accumulator manipulation not one clock");

  a_mul_time: assert property (
    issue && (opcode == 8'ha4) |=> !instr_done_ff [*3] ##1 instr_done_ff)
    else $error("multiply not four clocks");

  a_div_time: assert property (
    issue && (opcode == 8'h84) |=> !instr_done_ff [*7] ##1 instr_done_ff)
    else $error("divide not eight clocks");

  a_spare_nop: assert property (
    issue && (opcode == 8'ha5) |=>
      instr_done_ff && (instr_len_ff == 2'h1) && !flash_rd_ff)
    else $error("spare opcode differs from no-op");

  a_cjne_ind: assert property (
    issue && (opcode inside {8'hb6, 8'hb7}) |=>
      !instr_done_ff [*3] ##1 (instr_done_ff != branch_taken_ff))
    else $error("indirect compare branch not four or five clocks");

  a_taken_extra: assert property (
    $rose(branch_taken_ff) |->
      !instr_done_ff ##1 (instr_done_ff && state_ff == SCT_TAKEN))
    else $error("taken branch not exactly one clock longer");

  a_ext_to_flash: assert property (
    issue && (opcode == 8'he0) |=>
      flash_rd_ff && !flash_wr_ff && (flash_addr_ff == $past(data_ptr_value)))
    else $error("external move read did not reach flash");

endmodule // sct_timing

/* File: test/sct_flash_model.sv */
// Far-side model: on-chip program flash seen by the timing unit.
// Assumes: flash requests are one-cycle pulses on sys_clk.
module sct_flash_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Flash request
  input wire logic flash_rd_ff,
  input wire logic flash_wr_ff,
  input wire logic [15:0] flash_addr_ff,
  // Access log
  output int rd_cnt,
  output int wr_cnt,
  output logic [15:0] last_addr
);
  timeunit 1ns;
  timeprecision 1ns;

  ////////////////////////////////////////////////////////////////////////////
  // Flash takes moves
  // Address is caught in the pulse cycle only; later values are not trusted
  always @(posedge sys_clk) begin
    if (rst) begin
      rd_cnt <= 0;
      wr_cnt <= 0;
      last_addr <= 16'h0000;
    end else begin
      if (flash_rd_ff === 1'b1) begin
        rd_cnt <= rd_cnt + 1;
        last_addr <= flash_addr_ff;
      end
      if (flash_wr_ff === 1'b1) begin
        wr_cnt <= wr_cnt + 1;
        last_addr <= flash_addr_ff;
      end
    end
  end
endmodule // sct_flash_model

/* File: test/single_clock_cpu_timing_tb.sv */
// Testbench of the instruction timing unit: table of opcodes, then
// refused offers, back-to-back issue and reset in mid-instruction.
// Assumes: the flash model logs every flash request pulse.
module single_clock_cpu_timing_tb;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct {
    logic [7:0] op;
    logic tk;
    logic [1:0] len;
    logic [3:0] n;
    logic [3:0] fl;
    logic [15:0] addr;
  } sct_tb_row_t;

  logic sys_clk, rst, opcode_valid, branch_taken;
  logic [7:0] opcode, acc_value, ptr_reg_value;
  logic [15:0] data_ptr_value, pc_next;
  logic issue_ready_ff, instr_done_ff, cond_branch_ff, branch_taken_ff;
  logic [1:0] instr_len_ff;
  logic [3:0] instr_cycles_ff;
  logic bank_reg_op_ff, ptr_indirect_op_ff, flash_rd_ff, flash_wr_ff;
  logic [2:0] reg_index_ff;
  logic [15:0] flash_addr_ff, last_addr;
  int rd_cnt, wr_cnt, n_fail, total_checks, cyc_cnt;

  // Flags column: {bank register, pointer, flash read, flash write}
  sct_tb_row_t rows [33] = '{
    '{8'h28, 1'h0, 2'h1, 4'h1, 4'h8, 16'h0000},
    '{8'h5f, 1'h0, 2'h1, 4'h1, 4'h8, 16'h0000},
    '{8'hf9, 1'h0, 2'h1, 4'h1, 4'h8, 16'h0000},
    '{8'h26, 1'h0, 2'h1, 4'h2, 4'h4, 16'h0000},
    '{8'h57, 1'h0, 2'h1, 4'h2, 4'h4, 16'h0000},
    '{8'hf6, 1'h0, 2'h1, 4'h2, 4'h4, 16'h0000},
    '{8'h25, 1'h0, 2'h2, 4'h2, 4'h0, 16'h0000},
    '{8'he5, 1'h0, 2'h2, 4'h2, 4'h0, 16'h0000},
    '{8'h53, 1'h0, 2'h3, 4'h3, 4'h0, 16'h0000},
    '{8'h43, 1'h0, 2'h3, 4'h3, 4'h0, 16'h0000},
    '{8'h63, 1'h0, 2'h3, 4'h3, 4'h0, 16'h0000},
    '{8'h85, 1'h0, 2'h3, 4'h3, 4'h0, 16'h0000},
    '{8'h90, 1'h0, 2'h3, 4'h3, 4'h0, 16'h0000},
    '{8'h93, 1'h0, 2'h1, 4'h3, 4'h2, 16'h1a42},
    '{8'h83, 1'h0, 2'h1, 4'h3, 4'h2, 16'h0468},
    '{8'he0, 1'h0, 2'h1, 4'h3, 4'h2, 16'h1a30},
    '{8'hf0, 1'h0, 2'h1, 4'h3, 4'h1, 16'h1a30},
    '{8'he3, 1'h0, 2'h1, 4'h3, 4'h6, 16'h005a},
    '{8'he4, 1'h0, 2'h1, 4'h1, 4'h0, 16'h0000},
    '{8'hf4, 1'h0, 2'h1, 4'h1, 4'h0, 16'h0000},
    '{8'h23, 1'h0, 2'h1, 4'h1, 4'h0, 16'h0000},
    '{8'h33, 1'h0, 2'h1, 4'h1, 4'h0, 16'h0000},
    '{8'h03, 1'h0, 2'h1, 4'h1, 4'h0, 16'h0000},
    '{8'h13, 1'h0, 2'h1, 4'h1, 4'h0, 16'h0000},
    '{8'hc4, 1'h0, 2'h1, 4'h1, 4'h0, 16'h0000},
    // multiply ignores a stray branch outcome
    '{8'ha4, 1'h1, 2'h1, 4'h4, 4'h0, 16'h0000},
    '{8'h84, 1'h0, 2'h1, 4'h8, 4'h0, 16'h0000},
    '{8'ha5, 1'h0, 2'h1, 4'h1, 4'h0, 16'h0000},
    '{8'h00, 1'h0, 2'h1, 4'h1, 4'h0, 16'h0000},
    '{8'h40, 1'h0, 2'h2, 4'h2, 4'h0, 16'h0000},
    '{8'h40, 1'h1, 2'h2, 4'h3, 4'h0, 16'h0000},
    '{8'hb6, 1'h0, 2'h3, 4'h4, 4'h4, 16'h0000},
    '{8'hb7, 1'h1, 2'h3, 4'h5, 4'h4, 16'h0000}
  };

  sct_timing DUT (.sys_clk(sys_clk), .rst(rst),
    .opcode_valid(opcode_valid), .opcode(opcode), .acc_value(acc_value),
    .data_ptr_value(data_ptr_value), .pc_next(pc_next),
    .ptr_reg_value(ptr_reg_value), .branch_taken(branch_taken),
    .issue_ready_ff(issue_ready_ff), .instr_done_ff(instr_done_ff),
    .instr_len_ff(instr_len_ff), .instr_cycles_ff(instr_cycles_ff),
    .cond_branch_ff(cond_branch_ff), .branch_taken_ff(branch_taken_ff),
    .bank_reg_op_ff(bank_reg_op_ff), .ptr_indirect_op_ff(ptr_indirect_op_ff),
    .reg_index_ff(reg_index_ff), .flash_rd_ff(flash_rd_ff),
    .flash_wr_ff(flash_wr_ff), .flash_addr_ff(flash_addr_ff));

  sct_flash_model flash (.sys_clk(sys_clk), .rst(rst),
    .flash_rd_ff(flash_rd_ff), .flash_wr_ff(flash_wr_ff),
    .flash_addr_ff(flash_addr_ff), .rd_cnt(rd_cnt), .wr_cnt(wr_cnt),
    .last_addr(last_addr));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check_bit(input string name, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic check_val(input string name, input logic [15:0] e,
                           input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic test_done;
    if (n_fail == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Pester keeps offering no-ops while busy; they must be refused
  task automatic exec_row(input sct_tb_row_t r, input logic pester);
    int n;
    int rd0;
    int wr0;
    logic br;
    logic [2:0] ri;
    rd0 = rd_cnt;
    wr0 = wr_cnt;
    br = r.op inside {8'h40, 8'hb6, 8'hb7};
    ri = r.fl[3] ? r.op[2:0] : {2'h0, r.op[0]};
    @(posedge sys_clk);
    opcode_valid <= 1'b1;
    opcode <= r.op;
    branch_taken <= r.tk;
    @(posedge sys_clk);
    opcode_valid <= pester && (r.n > 4'h1);
    opcode <= 8'h00;
    #1;
    n = 1;
    check_val("length", 16'(r.len), 16'(instr_len_ff));
    while (instr_done_ff !== 1'b1 && n < 12) begin
      check_bit("ready while busy", 1'b0, issue_ready_ff);
      @(posedge sys_clk);
      opcode_valid <= pester && (n + 1 < int'(r.n));
      #1;
      n++;
    end
    check_val("clocks to done", 16'(r.n), 16'(n));
    check_val("cycle count", 16'(r.n), 16'(instr_cycles_ff));
    check_bit("bank flag", r.fl[3], bank_reg_op_ff);
    check_bit("pointer flag", r.fl[2], ptr_indirect_op_ff);
    check_bit("branch flag", br, cond_branch_ff);
    check_bit("taken flag", br && r.tk, branch_taken_ff);
    if (r.fl[3] || r.fl[2])
      check_val("register index", 16'(ri), 16'(reg_index_ff));
    @(posedge sys_clk);
    branch_taken <= 1'b0;
    #1;
    check_bit("done pulse end", 1'b0, instr_done_ff);
    check_bit("ready after", 1'b1, issue_ready_ff);
    check_val("flash reads", 16'(r.fl[1]), 16'(rd_cnt - rd0));
    check_val("flash writes", 16'(r.fl[0]), 16'(wr_cnt - wr0));
    if (r.fl[1] || r.fl[0])
      check_val("flash address", r.addr, last_addr);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 3000) begin
      n_fail++;
      test_done;
    end
  end

  initial begin
    n_fail = 0;
    total_checks = 0;
    cyc_cnt = 0;
    rst = 1'b1;
    opcode_valid = 1'b0;
    opcode = 8'h00;
    branch_taken = 1'b0;
    acc_value = 8'h12;
    data_ptr_value = 16'h1a30;
    pc_next = 16'h0456;
    ptr_reg_value = 8'h5a;
    @(posedge sys_clk);
    #1;
    check_bit("reset ready", 1'b1, issue_ready_ff);
    check_bit("reset done", 1'b0, instr_done_ff);
    @(posedge sys_clk);
    rst <= 1'b0;
    foreach (rows[i])
      exec_row(rows[i], 1'b0);
    exec_row(rows[26], 1'b1);
    @(posedge sys_clk);
    opcode_valid <= 1'b1;
    opcode <= 8'he4;
    @(posedge sys_clk);
    for (int i = 0; i < 3; i++) begin
      #1;
      check_bit("back to back done", 1'b1, instr_done_ff);
      @(posedge sys_clk);
      opcode_valid <= (i == 0);
    end
    #1;
    check_bit("back to back end", 1'b0, instr_done_ff);
    // Reset in mid-instruction clears the external move in flight
    @(posedge sys_clk);
    opcode_valid <= 1'b1;
    opcode <= 8'he0;
    @(posedge sys_clk);
    opcode_valid <= 1'b0;
    @(posedge sys_clk);
    rst <= 1'b1;
    @(posedge sys_clk);
    #1;
    check_bit("mid reset ready", 1'b1, issue_ready_ff);
    check_bit("mid reset done", 1'b0, instr_done_ff);
    check_val("mid reset address", 16'h0000, flash_addr_ff);
    @(posedge sys_clk);
    rst <= 1'b0;
    exec_row(rows[0], 1'b0);
    test_done;
  end
endmodule // single_clock_cpu_timing_tb
